// ### hw/spel_regs.vh
// Purpose: constants of the per-phy event log block
// Assumes: included by bare name from the design files
// Notes:   byte offsets are positions inside one log descriptor
`ifndef SPEL_REGS_VH
`define SPEL_REGS_VH

// negotiated rate selector from the phy layer
`define SPEL_RSEL_1G5        2'h0
`define SPEL_RSEL_3G0        2'h1
`define SPEL_RSEL_6G0        2'h2
`define SPEL_RSEL_12G0       2'h3

// negotiated link rate codes
`define SPEL_RATE_1G5        4'h8
`define SPEL_RATE_3G0        4'h9
`define SPEL_RATE_6G0        4'hA
`define SPEL_RATE_12G0       4'hB
`define SPEL_RATE_DISABLED   4'h0

// settings-change sequence counter
`define SPEL_GEN_UNKNOWN     8'h00
`define SPEL_GEN_MAX         8'hFF
`define SPEL_GEN_WRAP        8'h01

// peer reset cause forced value
`define SPEL_REASON_ZERO     4'h0

// descriptor header fields
`define SPEL_PCODE_PRIMARY   16'h0001
`define SPEL_PCODE_SECONDARY 16'h0002
`define SPEL_CTRL_BYTE       8'h00
`define SPEL_PARAM_LEN       8'h68
`define SPEL_PROTO_ID        8'h06
`define SPEL_NUM_PHYS        8'h01
`define SPEL_PHY_ID          8'h00
`define SPEL_PHY_DESC_LEN    8'h60

// event descriptor list
`define SPEL_EVT_DESC_LEN    8'h0C
`define SPEL_EVT_DESC_NUM    8'h04
`define SPEL_EVT_PVDT        32'h00000000

// byte offsets inside the descriptor
`define SPEL_OFS_CNT_BASE    7'h28
`define SPEL_OFS_CNT_END     7'h38
`define SPEL_OFS_EVT_BASE    7'h3C
`define SPEL_OFS_END         7'h6C
`define SPEL_OFS_LAST        7'h6B

// counter reset and maximum values
`define SPEL_CNT_RESET       32'h00000000
`define SPEL_CNT_MAX         32'hFFFFFFFF

`endif

// ### hw/spel_sat_cnt.v
// Purpose: 32-bit event counter that stops at its maximum
// Assumes: inc_i is a one-cycle pulse on clk_i
// Notes:   only the power-on reset clears it
`include "spel_regs.vh"

module spel_sat_cnt (
    // clock and reset
    input  wire        clk_i,
    input  wire        rstn_i,
    // event
    input  wire        inc_i,
    // count
    output reg  [31:0] count_o
);

    always @(posedge clk_i) begin
        if (!rstn_i) begin
            count_o <= `SPEL_CNT_RESET; // RQ24
        end else if (inc_i && (count_o != `SPEL_CNT_MAX)) begin // RQ13
            count_o <= count_o + 32'h00000001;
        end
    end

endmodule // spel_sat_cnt

// ### hw/spel_phy_event_log.v
// Purpose: per-phy link statistics, identify capture and log descriptor read-out
// Assumes: all phy event inputs come from logic on clk_i; events are one-cycle pulses
// Notes:   a descriptor byte is read one cycle after rd_en_i
//          indexes past the last descriptor byte read as 00h
//
// Notes on behaviour
// RQ1: link rate field follows the result of the most recent link reset.
// RQ2: with phy enabled, 1.5G encodes as 8h and 3.0G as 9h.
// RQ3: with phy enabled, 6.0G encodes as Ah and 12.0G as Bh.
// RQ4: eight-bit generation counter adds one on every phy setting change.
// RQ5: generation 00h means unknown; after FFh it wraps to 01h.
// RQ6: SAS or expander peer: peer cause is the last received identify cause.
// RQ7: SATA peer: peer cause becomes 0h after first device-to-host register frame.
// RQ8: virtual phy always reports peer cause 0h.
// RQ9: local cause is the one placed in the last transmitted identify frame.
// RQ10: capture peer device type, port bits, address and phy id from identify.
// RQ11: own address reported exactly as transmitted during identify.
// RQ12: invalid dwords count only outside phy reset sequences.
// RQ13: all four error counters saturate at their maximum.
// RQ14: disparity errors count one per bad word while dword sync is held.
// RQ15: no disparity counting while dword sync is lost.
// RQ16: count each sync loss that restarts the link reset sequence.
// RQ17: count each phy reset failed for lack of sync in speed match.
// RQ18: event descriptor length reads as 0Ch.
// RQ19: number of event descriptors reads as 04h.
// RQ20: sources 01h to 04h, each followed by its count.
// RQ21: peak detector threshold reads all zeros in each event descriptor.
// RQ22: counts run from power-on and survive link resets.
// RQ23: parameter code 0001h for primary port, 0002h for secondary.
// RQ24: error counters are 32 bits and clear at power-on reset.
// RQ25: identify values and rate update together when identification completes.
`include "spel_regs.vh"

module spel_phy_event_log (
    // clock and reset
    input  wire        clk_i,
    input  wire        rstn_i,
    // phy status
    input  wire        phy_enable_i,
    input  wire        virtual_phy_i,
    input  wire        attached_sata_i,
    // identification result, taken on ident_done_i
    input  wire        ident_done_i,
    input  wire [1:0]  rate_sel_i,
    input  wire [3:0]  tx_reason_i,
    input  wire [63:0] tx_sas_addr_i,
    input  wire [2:0]  rx_dev_type_i,
    input  wire [3:0]  rx_reason_i,
    input  wire [2:0]  rx_init_bits_i,
    input  wire [2:0]  rx_tgt_bits_i,
    input  wire [63:0] rx_sas_addr_i,
    input  wire [7:0]  rx_phy_id_i,
    // sata register device-to-host frame received
    input  wire        sata_d2h_rx_i,
    // phy setting changed
    input  wire        setting_change_i,
    // link events
    input  wire        invalid_dword_i,
    input  wire        in_reset_seq_i,
    input  wire        disp_err_i,
    input  wire        dword_sync_i,
    input  wire        sync_drop_i,
    input  wire        reset_fail_i,
    // descriptor read port
    input  wire        rd_en_i,
    input  wire        rd_port_sel_i,
    input  wire [6:0]  rd_idx_i,
    output reg  [7:0]  rd_data_o,
    output reg         rd_valid_o,
    // identification values
    output reg  [3:0]  link_rate_o,
    output reg  [7:0]  gen_code_o,
    output reg  [3:0]  peer_reason_o,
    output reg  [3:0]  local_reason_o,
    output reg  [2:0]  att_dev_type_o,
    output reg  [2:0]  att_init_bits_o,
    output reg  [2:0]  att_tgt_bits_o,
    output reg  [63:0] own_sas_addr_o,
    output reg  [63:0] att_sas_addr_o,
    output reg  [7:0]  att_phy_id_o,
    // event counts
    output wire [31:0] invalid_dword_cnt_o,
    output wire [31:0] disp_err_cnt_o,
    output wire [31:0] sync_drop_tally_o,
    output wire [31:0] reset_fail_cnt_o
);

    // counter events and counts, index 0..3 matches sources 01h..04h
    wire [3:0]   evt_inc;
    wire [127:0] evt_cnt;

    // sata peer waits for its first register frame
    reg          sata_wait_r;
    reg          sata_wait_nxt;
    reg  [3:0]   peer_reason_nxt;
    reg  [3:0]   rate_nxt;
    reg  [7:0]   gen_nxt;
    reg  [7:0]   byte_nxt;

    // descriptor index helpers
    reg  [6:0]   cnt_off;
    reg  [6:0]   evt_off;
    reg  [1:0]   evt_sel;
    reg  [3:0]   evt_pos;

    // parameter codes, split into bytes by the read mux
    localparam [15:0] pcode_pri = `SPEL_PCODE_PRIMARY;
    localparam [15:0] pcode_sec = `SPEL_PCODE_SECONDARY;

    // start of event descriptors two to four, relative to the first
    localparam [6:0]  evt_ofs_2 = 7'h0C;
    localparam [6:0]  evt_ofs_3 = 7'h18;
    localparam [6:0]  evt_ofs_4 = 7'h24;

    // rate code of a selector
    function [3:0] rate_code;
        input [1:0] sel;
        begin
            case (sel)
                `SPEL_RSEL_1G5:  rate_code = `SPEL_RATE_1G5;  // RQ2
                `SPEL_RSEL_3G0:  rate_code = `SPEL_RATE_3G0;  // RQ2
                `SPEL_RSEL_6G0:  rate_code = `SPEL_RATE_6G0;  // RQ3
                `SPEL_RSEL_12G0: rate_code = `SPEL_RATE_12G0; // RQ3
                default:         rate_code = `SPEL_RATE_DISABLED;
            endcase
        end
    endfunction

    // big-endian byte of a 32-bit value
    function [7:0] be_byte32;
        input [31:0] v;
        input [1:0]  b;
        begin
            case (b)
                2'h0:    be_byte32 = v[31:24];
                2'h1:    be_byte32 = v[23:16];
                2'h2:    be_byte32 = v[15:8];
                default: be_byte32 = v[7:0];
            endcase
        end
    endfunction

    // big-endian byte of a 64-bit value
    function [7:0] be_byte64;
        input [63:0] v;
        input [2:0]  b;
        begin
            be_byte64 = v[63 - {b, 3'h0} -: 8];
        end
    endfunction

    // count of one event source
    function [31:0] cnt_of;
        input [127:0] all;
        input [1:0]   k;
        begin
            cnt_of = all[{k, 5'h00} +: 32];
        end
    endfunction

    // event qualification
    // a pulse outside its qualifier is dropped here, so the counters stay plain
    assign evt_inc[0] = invalid_dword_i && !in_reset_seq_i;  // RQ12
    assign evt_inc[1] = disp_err_i && dword_sync_i;          // RQ14 RQ15
    assign evt_inc[2] = sync_drop_i;                         // RQ16
    assign evt_inc[3] = reset_fail_i;                        // RQ17

    // four saturating counters; only power-on reset clears them
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_cnt
            spel_sat_cnt u_cnt (
                .clk_i   (clk_i),
                .rstn_i  (rstn_i),
                .inc_i   (evt_inc[gi]),
                .count_o (evt_cnt[gi*32 +: 32])
            ); // RQ22 RQ13 RQ24
        end
    endgenerate

    assign invalid_dword_cnt_o = evt_cnt[31:0];
    assign disp_err_cnt_o      = evt_cnt[63:32];
    assign sync_drop_tally_o   = evt_cnt[95:64];
    assign reset_fail_cnt_o    = evt_cnt[127:96];

    // generation code
    // 00h stays reserved for unknown, so the wrap lands on 01h
    always @* begin
        gen_nxt = gen_code_o;
        if (setting_change_i) begin
            if (gen_code_o == `SPEL_GEN_MAX) begin
                gen_nxt = `SPEL_GEN_WRAP;          // RQ5
            end else begin
                gen_nxt = gen_code_o + 8'h01;      // RQ4
            end
        end
    end

    // link rate and peer reason of a completed identification
    // a sata peer keeps its old cause until its first register frame arrives
    // a virtual phy overrides every other source on every cycle
    always @* begin
        rate_nxt        = link_rate_o;
        peer_reason_nxt = peer_reason_o;
        sata_wait_nxt   = sata_wait_r;
        if (ident_done_i) begin
            if (phy_enable_i) begin
                rate_nxt = rate_code(rate_sel_i);  // RQ1
            end else begin
                rate_nxt = `SPEL_RATE_DISABLED;
            end
            if (virtual_phy_i) begin
                peer_reason_nxt = `SPEL_REASON_ZERO;    // RQ8
                sata_wait_nxt   = 1'b0;
            end else if (attached_sata_i) begin
                sata_wait_nxt   = 1'b1;
            end else begin
                peer_reason_nxt = rx_reason_i;          // RQ6
                sata_wait_nxt   = 1'b0;
            end
        end
        if (sata_d2h_rx_i && attached_sata_i && !virtual_phy_i) begin
            if (sata_wait_r || (ident_done_i && sata_wait_nxt)) begin
                peer_reason_nxt = `SPEL_REASON_ZERO;    // RQ7
                sata_wait_nxt   = 1'b0;
            end
        end
        if (virtual_phy_i) begin
            peer_reason_nxt = `SPEL_REASON_ZERO;        // RQ8
        end
    end

    always @(posedge clk_i) begin
        if (!rstn_i) begin
            gen_code_o      <= `SPEL_GEN_UNKNOWN;
            link_rate_o     <= `SPEL_RATE_DISABLED;
            peer_reason_o   <= `SPEL_REASON_ZERO;
            sata_wait_r     <= 1'b0;
        end else begin
            gen_code_o      <= gen_nxt;
            link_rate_o     <= rate_nxt;           // RQ25
            peer_reason_o   <= peer_reason_nxt;
            sata_wait_r     <= sata_wait_nxt;
        end
    end

    // identify frame capture, all fields on the same edge
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            local_reason_o  <= 4'h0;
            att_dev_type_o  <= 3'h0;
            att_init_bits_o <= 3'h0;
            att_tgt_bits_o  <= 3'h0;
            own_sas_addr_o  <= 64'h0000000000000000;
            att_sas_addr_o  <= 64'h0000000000000000;
            att_phy_id_o    <= 8'h00;
        end else if (ident_done_i) begin       // RQ25
            local_reason_o  <= tx_reason_i;     // RQ9
            att_dev_type_o  <= rx_dev_type_i;   // RQ10
            att_init_bits_o <= rx_init_bits_i;  // RQ10
            att_tgt_bits_o  <= rx_tgt_bits_i;   // RQ10
            own_sas_addr_o  <= tx_sas_addr_i;   // RQ11
            att_sas_addr_o  <= rx_sas_addr_i;   // RQ10
            att_phy_id_o    <= rx_phy_id_i;     // RQ10
        end
    end

    // descriptor index decode
    // only the low nibble of a position is needed, so it is subtracted on four bits
    always @* begin
        cnt_off = rd_idx_i - `SPEL_OFS_CNT_BASE;
        evt_off = rd_idx_i - `SPEL_OFS_EVT_BASE;
        evt_sel = 2'h0;
        evt_pos = evt_off[3:0];
        if (evt_off >= evt_ofs_4) begin
            evt_sel = 2'h3;
            evt_pos = evt_off[3:0] - evt_ofs_4[3:0];
        end else if (evt_off >= evt_ofs_3) begin
            evt_sel = 2'h2;
            evt_pos = evt_off[3:0] - evt_ofs_3[3:0];
        end else if (evt_off >= evt_ofs_2) begin
            evt_sel = 2'h1;
            evt_pos = evt_off[3:0] - evt_ofs_2[3:0];
        end
    end

    // descriptor byte selection
    always @* begin
        byte_nxt = 8'h00;
        if (rd_idx_i < 7'h10) begin
            case (rd_idx_i[3:0])
                4'h0: byte_nxt = rd_port_sel_i ? pcode_sec[15:8] : pcode_pri[15:8]; // RQ23
                4'h1: byte_nxt = rd_port_sel_i ? pcode_sec[7:0] : pcode_pri[7:0];   // RQ23
                4'h2: byte_nxt = `SPEL_CTRL_BYTE;
                4'h3: byte_nxt = `SPEL_PARAM_LEN;
                4'h4: byte_nxt = `SPEL_PROTO_ID;
                4'h6: byte_nxt = gen_code_o;
                4'h7: byte_nxt = `SPEL_NUM_PHYS;
                4'h9: byte_nxt = `SPEL_PHY_ID;
                4'hB: byte_nxt = `SPEL_PHY_DESC_LEN;
                4'hC: byte_nxt = {1'b0, att_dev_type_o, peer_reason_o};
                4'hD: byte_nxt = {local_reason_o, link_rate_o};
                4'hE: byte_nxt = {4'h0, att_init_bits_o, 1'b0};
                4'hF: byte_nxt = {4'h0, att_tgt_bits_o, 1'b0};
                default: byte_nxt = 8'h00;
            endcase
        end else if (rd_idx_i < 7'h18) begin
            byte_nxt = be_byte64(own_sas_addr_o, rd_idx_i[2:0]);   // RQ11
        end else if (rd_idx_i < 7'h20) begin
            byte_nxt = be_byte64(att_sas_addr_o, rd_idx_i[2:0]);
        end else if (rd_idx_i == 7'h20) begin
            byte_nxt = att_phy_id_o;
        end else if (rd_idx_i >= `SPEL_OFS_CNT_BASE && rd_idx_i < `SPEL_OFS_CNT_END) begin
            byte_nxt = be_byte32(cnt_of(evt_cnt, cnt_off[3:2]), cnt_off[1:0]);
        end else if (rd_idx_i == 7'h3A) begin
            byte_nxt = `SPEL_EVT_DESC_LEN;                          // RQ18
        end else if (rd_idx_i == 7'h3B) begin
            byte_nxt = `SPEL_EVT_DESC_NUM;                          // RQ19
        end else if (rd_idx_i >= `SPEL_OFS_EVT_BASE && rd_idx_i < `SPEL_OFS_END) begin
            if (evt_pos == 4'h3) begin
                byte_nxt = {6'h00, evt_sel} + 8'h01;                // RQ20
            end else if (evt_pos >= 4'h4 && evt_pos < 4'h8) begin
                byte_nxt = be_byte32(cnt_of(evt_cnt, evt_sel), evt_pos[1:0]); // RQ20
            end else if (evt_pos >= 4'h8) begin
                byte_nxt = be_byte32(`SPEL_EVT_PVDT, evt_pos[1:0]); // RQ21
            end else begin
                byte_nxt = 8'h00;
            end
        end
    end

    // registered read answer
    // rd_data_o holds the last byte read until the next request
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            rd_data_o  <= 8'h00;
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= rd_en_i;
            if (rd_en_i) begin
                rd_data_o <= byte_nxt;
            end
        end
    end

endmodule // spel_phy_event_log

// ### sim/spel_phy_event_log_chk.sv
// Purpose: port-level assertions for the per-phy event log
// Assumes: one clock, synchronous active-low reset
// Notes:   sees only the top module's ports, attached by bind
module spel_chk (
    input logic        clk_i, rstn_i, phy_enable_i, virtual_phy_i, ident_done_i, setting_change_i,
    input logic        in_reset_seq_i, disp_err_i, dword_sync_i, sync_drop_i, reset_fail_i, rd_en_i, rd_valid_o,
    input logic [1:0]  rate_sel_i,
    input logic [6:0]  rd_idx_i,
    input logic [7:0]  rd_data_o, gen_code_o,
    input logic [3:0]  link_rate_o, peer_reason_o,
    input logic [31:0] invalid_dword_cnt_o, disp_err_cnt_o, sync_drop_tally_o, reset_fail_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_rd_req;
        rd_en_i && rd_idx_i == 7'h3B;
    endsequence
    sequence s_rd_ans;
        rd_valid_o && rd_data_o == 8'h04;
    endsequence

    a_rate_code: assert property (ident_done_i && phy_enable_i |=> link_rate_o == {2'h2, $past(rate_sel_i)})
        else $error("link rate code wrong");
    a_gen_step: assert property (setting_change_i |=>
        gen_code_o == (($past(gen_code_o) == 8'hFF) ? 8'h01 : $past(gen_code_o) + 8'h01))
        else $error("generation step wrong");
    a_gen_known: assert property (gen_code_o != 8'h00 |=> gen_code_o != 8'h00)
        else $error("generation returned to unknown");
    a_inv_block: assert property (in_reset_seq_i |=> $stable(invalid_dword_cnt_o))
        else $error("invalid dword counted in reset");
    a_disp_gate: assert property (!dword_sync_i |=> $stable(disp_err_cnt_o))
        else $error("disparity counted without sync");
    a_disp_step: assert property (disp_err_i && dword_sync_i && disp_err_cnt_o != 32'hFFFFFFFF |=>
        disp_err_cnt_o == $past(disp_err_cnt_o) + 32'h1)
        else $error("disparity count step wrong");
    a_sync_step: assert property (sync_drop_i && sync_drop_tally_o != 32'hFFFFFFFF |=>
        sync_drop_tally_o == $past(sync_drop_tally_o) + 32'h1)
        else $error("sync drop step wrong");
    a_fail_sat: assert property (reset_fail_i |=> reset_fail_cnt_o ==
        (($past(reset_fail_cnt_o) == 32'hFFFFFFFF) ? 32'hFFFFFFFF : $past(reset_fail_cnt_o) + 32'h1))
        else $error("reset fail count wrong");
    a_virt_zero: assert property (virtual_phy_i ##1 virtual_phy_i |-> peer_reason_o == 4'h0)
        else $error("virtual peer cause not zero");
    a_read_ans: assert property (s_rd_req |=> s_rd_ans)
        else $error("descriptor count byte wrong");
endmodule // spel_chk

bind spel_phy_event_log spel_chk u_chk (.clk_i, .rstn_i, .phy_enable_i, .virtual_phy_i, .ident_done_i,
    .setting_change_i, .in_reset_seq_i, .disp_err_i, .dword_sync_i, .sync_drop_i, .reset_fail_i, .rd_en_i,
    .rd_valid_o, .rate_sel_i, .rd_idx_i, .rd_data_o, .gen_code_o, .link_rate_o, .peer_reason_o,
    .invalid_dword_cnt_o, .disp_err_cnt_o, .sync_drop_tally_o, .reset_fail_cnt_o);

// ### sim/spel_peer_model.sv
// Purpose: far-side phy: identify exchange and link events
// Assumes: driven just after the rising edge of clk_i
// Notes:   identify fields are scrambled once taken
module spel_peer (
    input  logic        clk_i,
    output logic        done_o, d2h_o, inv_o, inrst_o, disp_o, sync_o, drop_o, fail_o,
    output logic [1:0]  rate_o,
    output logic [3:0]  txr_o, rxr_o,
    output logic [2:0]  dev_o, ini_o, tgt_o,
    output logic [7:0]  pid_o,
    output logic [63:0] txa_o, rxa_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {done_o, d2h_o, inv_o, inrst_o, disp_o, drop_o, fail_o, rate_o, txr_o, rxr_o} = '0;
        {dev_o, ini_o, tgt_o, pid_o, txa_o, rxa_o} = '0;
        sync_o = 1'b1;
    end
    task ident(input logic [1:0] r);
        logic [31:0] rv;
        @(posedge clk_i);
        #1;
        rv = $urandom;
        {txr_o, rxr_o, dev_o, ini_o, tgt_o, pid_o} = rv[24:0];
        txa_o = {$urandom, $urandom};
        rxa_o = {$urandom, $urandom};
        rate_o = r;
        done_o = 1'b1;
        @(posedge clk_i);
        #1;
        done_o = 1'b0;
        {txr_o, rxr_o, dev_o, ini_o, tgt_o, pid_o, txa_o, rxa_o} = ~{txr_o, rxr_o, dev_o, ini_o, tgt_o, pid_o, txa_o, rxa_o};
    endtask
    task d2h;
        @(posedge clk_i);
        #1;
        d2h_o = 1'b1;
        @(posedge clk_i);
        #1;
        d2h_o = 1'b0;
    endtask
    task burst(input int n);
        logic [31:0] rv;
        repeat (n) begin
            @(posedge clk_i);
            #1;
            rv = $urandom;
            {inv_o, inrst_o, disp_o, sync_o, drop_o, fail_o} = rv[5:0];
        end
        @(posedge clk_i);
        #1;
        {inv_o, inrst_o, disp_o, sync_o, drop_o, fail_o} = 6'h04;
    endtask
endmodule // spel_peer

// ### sim/spel_phy_event_log_tb_top.sv
// Purpose: self-checking bench of the per-phy event log
// Assumes: 125 MHz clock, synchronous active-low reset held 10 cycles
// Notes:   expected values come from a mirror kept beside the design
module spel_phy_event_log_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i, rstn_i, phy_enable_i, virtual_phy_i, attached_sata_i, setting_change_i, rd_en_i, rd_port_sel_i;
    logic [6:0]  rd_idx_i;
    wire         ident_done_i, sata_d2h_rx_i, invalid_dword_i, in_reset_seq_i, disp_err_i, dword_sync_i;
    wire         sync_drop_i, reset_fail_i, rd_valid_o;
    wire  [1:0]  rate_sel_i;
    wire  [2:0]  rx_dev_type_i, rx_init_bits_i, rx_tgt_bits_i, att_dev_type_o, att_init_bits_o, att_tgt_bits_o;
    wire  [3:0]  tx_reason_i, rx_reason_i, link_rate_o, peer_reason_o, local_reason_o;
    wire  [7:0]  rx_phy_id_i, rd_data_o, gen_code_o, att_phy_id_o;
    wire  [31:0] invalid_dword_cnt_o, disp_err_cnt_o, sync_drop_tally_o, reset_fail_cnt_o;
    wire  [63:0] tx_sas_addr_i, rx_sas_addr_i, own_sas_addr_o, att_sas_addr_o;
    int          errors, total_checks;
    logic [3:0]  e_rate, e_peer, e_loc;
    logic [2:0]  e_dev, e_ini, e_tgt;
    logic [7:0]  e_gen, e_pid;
    logic [63:0] e_own, e_att;
    logic [31:0] e_cnt [4];

    spel_phy_event_log u_dut (.clk_i, .rstn_i, .phy_enable_i, .virtual_phy_i, .attached_sata_i, .ident_done_i,
        .rate_sel_i, .tx_reason_i, .tx_sas_addr_i, .rx_dev_type_i, .rx_reason_i, .rx_init_bits_i, .rx_tgt_bits_i,
        .rx_sas_addr_i, .rx_phy_id_i, .sata_d2h_rx_i, .setting_change_i, .invalid_dword_i, .in_reset_seq_i,
        .disp_err_i, .dword_sync_i, .sync_drop_i, .reset_fail_i, .rd_en_i, .rd_port_sel_i, .rd_idx_i, .rd_data_o,
        .rd_valid_o, .link_rate_o, .gen_code_o, .peer_reason_o, .local_reason_o, .att_dev_type_o, .att_init_bits_o,
        .att_tgt_bits_o, .own_sas_addr_o, .att_sas_addr_o, .att_phy_id_o, .invalid_dword_cnt_o, .disp_err_cnt_o,
        .sync_drop_tally_o, .reset_fail_cnt_o);
    spel_peer u_peer (.clk_i, .done_o(ident_done_i), .d2h_o(sata_d2h_rx_i), .inv_o(invalid_dword_i),
        .inrst_o(in_reset_seq_i), .disp_o(disp_err_i), .sync_o(dword_sync_i), .drop_o(sync_drop_i),
        .fail_o(reset_fail_i), .rate_o(rate_sel_i), .txr_o(tx_reason_i), .rxr_o(rx_reason_i), .dev_o(rx_dev_type_i),
        .ini_o(rx_init_bits_i), .tgt_o(rx_tgt_bits_i), .pid_o(rx_phy_id_i), .txa_o(tx_sas_addr_i),
        .rxa_o(rx_sas_addr_i));

    function automatic logic [31:0] sat(input logic [31:0] v);
        return (v == 32'hFFFFFFFF) ? v : v + 32'h1;
    endfunction
    // mirror of the visible state, updated on the same edges as the design
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            {e_rate, e_peer, e_loc, e_dev, e_ini, e_tgt, e_gen, e_pid, e_own, e_att} = '0;
            e_cnt = '{default: 32'h0};
        end else begin
            if (invalid_dword_i && !in_reset_seq_i) e_cnt[0] = sat(e_cnt[0]);
            if (disp_err_i && dword_sync_i) e_cnt[1] = sat(e_cnt[1]);
            if (sync_drop_i) e_cnt[2] = sat(e_cnt[2]);
            if (reset_fail_i) e_cnt[3] = sat(e_cnt[3]);
            if (setting_change_i) e_gen = (e_gen == 8'hFF) ? 8'h01 : e_gen + 8'h01;
            if (ident_done_i) begin
                e_rate = phy_enable_i ? {2'h2, rate_sel_i} : 4'h0;
                {e_loc, e_own, e_att, e_dev, e_ini, e_tgt, e_pid} = {tx_reason_i, tx_sas_addr_i, rx_sas_addr_i,
                    rx_dev_type_i, rx_init_bits_i, rx_tgt_bits_i, rx_phy_id_i};
                if (!attached_sata_i) e_peer = rx_reason_i;
            end
            if (sata_d2h_rx_i && attached_sata_i) e_peer = 4'h0;
            if (virtual_phy_i) e_peer = 4'h0;
        end
    end
    function automatic logic [7:0] exp_byte(input logic p, input int i);
        int k;
        k = (i - 60) % 12;
        case (i) inside
            1: return p ? 8'h02 : 8'h01;
            3: return 8'h68;
            4: return 8'h06;
            6: return e_gen;
            7: return 8'h01;
            11: return 8'h60;
            12: return {1'b0, e_dev, e_peer};
            13: return {e_loc, e_rate};
            14: return {4'h0, e_ini, 1'b0};
            15: return {4'h0, e_tgt, 1'b0};
            [16:23]: return e_own[8 * (23 - i) +: 8];
            [24:31]: return e_att[8 * (31 - i) +: 8];
            32: return e_pid;
            [40:55]: return e_cnt[(i - 40) / 4][8 * (3 - (i - 40) % 4) +: 8];
            58: return 8'h0C;
            59: return 8'h04;
            [60:107]: return (k == 3) ? 8'((i - 60) / 12 + 1) : (k >= 4 && k < 8) ? e_cnt[(i - 60) / 12][8 * (7 - k) +: 8] : 8'h00;
            default: return 8'h00;
        endcase
    endfunction
    task chk(input logic [255:0] g, input logic [255:0] e);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %0t value %h expected %h", $time, g, e);
        end
    endtask
    task chk_rd(input logic p, input int i);
        total_checks++;
        if (rd_valid_o !== 1'b1 || rd_data_o !== exp_byte(p, i)) begin
            errors++;
            $display("[FAIL] %0t byte %0d port %0d read %h", $time, i, p, rd_data_o);
        end
    endtask
    task chk_id;
        chk({link_rate_o, local_reason_o, peer_reason_o, att_dev_type_o, att_init_bits_o, att_tgt_bits_o, own_sas_addr_o,
            att_sas_addr_o, att_phy_id_o}, {e_rate, e_loc, e_peer, e_dev, e_ini, e_tgt, e_own, e_att, e_pid});
    endtask
    task chk_cnt;
        chk({invalid_dword_cnt_o, disp_err_cnt_o, sync_drop_tally_o, reset_fail_cnt_o}, {e_cnt[0], e_cnt[1], e_cnt[2], e_cnt[3]});
    endtask
    task sweep(input logic p);
        for (int i = 0; i < 112; i++) begin
            rd_port_sel_i = p;
            rd_idx_i = 7'(i);
            rd_en_i = 1'b1;
            @(posedge clk_i);
            #1;
            chk_rd(p, i);
        end
        rd_en_i = 1'b0;
    endtask
    task summarize;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    initial begin
        #400000;
        errors++;
        $display("[FAIL] %0t run did not finish", $time);
        summarize();
    end
    initial begin
        errors = 0;
        total_checks = 0;
        {rstn_i, phy_enable_i, virtual_phy_i, attached_sata_i, setting_change_i, rd_en_i, rd_port_sel_i} = '0;
        rd_idx_i = 7'h00;
        void'($urandom(92315));
        repeat (10) @(posedge clk_i);
        #1;
        rstn_i = 1'b1;
        chk({gen_code_o, link_rate_o, peer_reason_o}, 16'h0000);
        chk_cnt();
        phy_enable_i = 1'b1;
        for (int r = 0; r < 4; r++) begin
            u_peer.ident(2'(r));
            chk_id();
        end
        phy_enable_i = 1'b0;
        u_peer.ident(2'($urandom));
        chk_id();
        phy_enable_i = 1'b1;
        attached_sata_i = 1'b1;
        u_peer.ident(2'($urandom));
        chk_id();
        u_peer.d2h();
        chk_id();
        attached_sata_i = 1'b0;
        virtual_phy_i = 1'b1;
        u_peer.ident(2'($urandom));
        chk_id();
        virtual_phy_i = 1'b0;
        setting_change_i = 1'b1;
        repeat (270) @(posedge clk_i);
        #1;
        repeat (20) begin
            setting_change_i = 1'($urandom);
            @(posedge clk_i);
            #1;
        end
        setting_change_i = 1'b0;
        chk(gen_code_o, e_gen);
        repeat (4) begin
            u_peer.burst(60 + $urandom % 40);
            chk_cnt();
            u_peer.ident(2'($urandom));
            chk_cnt();
        end
        sweep(1'b0);
        sweep(1'b1);
        summarize();
    end
endmodule // spel_phy_event_log_tb_top
